// ===== dcc_pkg.sv
// Purpose: Shared constants and types for the dual comparator control block.
// Assumes: APB with 32-bit data; one aligned word per register.
// Notes:   Offsets are byte addresses.
package dcc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET     = 8'h00;
	localparam logic [7:0] IRQ_STAT_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h08;
	localparam logic [7:0] IDLE_OFFSET     = 8'h0c;

	// ----------------------------------------------------------------
	// Field positions of the control register
	// ----------------------------------------------------------------
	localparam int STOP_IN_IDLE_BIT = 15;
	localparam int CMP2_EVENT_BIT   = 13;
	localparam int CMP1_EVENT_BIT   = 12;
	localparam int CMP2_EN_BIT      = 11;
	localparam int CMP1_EN_BIT      = 10;
	localparam int CMP2_DRIVE_BIT   = 9;
	localparam int CMP1_DRIVE_BIT   = 8;
	localparam int CMP2_RESULT_BIT  = 7;
	localparam int CMP1_RESULT_BIT  = 6;
	localparam int CMP2_INV_BIT     = 5;
	localparam int CMP1_INV_BIT     = 4;
	localparam int CMP2_MINUS_BIT   = 3;
	localparam int CMP2_PLUS_BIT    = 2;
	localparam int CMP1_MINUS_BIT   = 1;
	localparam int CMP1_PLUS_BIT    = 0;

	// Bits software may write directly; events and results are excluded.
	localparam logic [15:0] CTRL_WRITE_MASK = 16'h8f3f;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam logic [1:0]  IRQ_RESET       = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic invert;
		logic minus_sel;
		logic plus_sel;
	} dcc_cmp_cfg_t;

	typedef struct packed {
		logic result;
		logic changed;
	} dcc_cmp_stat_t;

endpackage

// ===== dcc_sync2.sv
// Purpose: Two-flop synchroniser for one asynchronous level.
// Assumes: Input comes from outside the sys_clk domain.
// Notes:   The first flop feeds only the second.
`timescale 1ns/10ps
module dcc_sync2 (
	input  wire logic sys_clk, // Clock.
	input  wire logic rst_n,   // Asynchronous reset, active low.
	input  wire logic d_in,    // Asynchronous level.
	output logic      q_out    // Synchronised level.
);
	logic meta_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			q_out    <= 1'b0;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule

// ===== dcc_channel.sv
// Purpose: One comparator channel: polarity and change detection.
// Assumes: raw_sync is already in the sys_clk domain.
// Notes:   A disabled comparator reports a steady low result.
`timescale 1ns/10ps
module dcc_channel (
	input  wire logic                  sys_clk,  // Clock.
	input  wire logic                  rst_n,    // Asynchronous reset, active low.
	input  wire dcc_pkg::dcc_cmp_cfg_t cfg,      // Channel configuration.
	input  wire logic                  raw_sync, // Core output, high when plus above minus.
	output dcc_pkg::dcc_cmp_stat_t     stat      // Result and one-cycle change pulse.
);
	logic result_reg;
	logic result_next;

	always_comb begin
		result_next = cfg.enable & (raw_sync ^ cfg.invert);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= 1'b0;
		end else begin
			result_reg <= result_next;
		end
	end

	assign stat.result  = result_reg;
	assign stat.changed = result_reg ^ result_next;
endmodule

// ===== dcc_top.sv
// Purpose: APB register block controlling two analog comparators.
// Assumes: Comparator core outputs are asynchronous to sys_clk.
// Notes:   Zero wait states; unmapped addresses read zero and raise pslverr.
//
// Behaviour
// - Sticky change flags at bits 13 and 12 set when a result changes.
// - Enable bits 11 and 10 switch comparators 2 and 1 on.
// - Pin drive enable drives result to pin; software routes pin first.
// - Invert clear: result high when plus input exceeds minus input.
// - Low-byte results are read-only; other low bits read-write; reset zero.
`timescale 1ns/10ps
module dcc_top (
	input  wire logic        sys_clk,      // Clock, 100 MHz.
	input  wire logic        rst_n,        // Asynchronous reset, active low.
	input  wire logic        psel,         // APB select.
	input  wire logic        penable,      // APB enable.
	input  wire logic        pwrite,       // APB direction.
	input  wire logic [7:0]  paddr,        // APB byte address.
	input  wire logic [31:0] pwdata,       // APB write data.
	input  wire logic [3:0]  pstrb,        // APB byte strobes.
	output logic      [31:0] prdata,       // APB read data.
	output logic             pready,       // APB ready.
	output logic             pslverr,      // APB error.
	input  wire logic        cmp1_raw,     // Comparator 1 core output.
	input  wire logic        cmp2_raw,     // Comparator 2 core output.
	input  wire logic        idle_mode,    // Device idle indication, sys_clk domain.
	output logic             cmp1_core_en, // Comparator 1 power enable.
	output logic             cmp2_core_en, // Comparator 2 power enable.
	output logic [1:0]       cmp1_sel,     // Comparator 1 minus and plus select.
	output logic [1:0]       cmp2_sel,     // Comparator 2 minus and plus select.
	output logic             cmp1_pin_out, // Comparator 1 result to pin.
	output logic             cmp1_pin_oe,  // Comparator 1 pin drive enable.
	output logic             cmp2_pin_out, // Comparator 2 result to pin.
	output logic             cmp2_pin_oe,  // Comparator 2 pin drive enable.
	output logic             irq           // Interrupt, active high level.
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [1:0]  stat_reg;
	logic [1:0]  stat_next;
	logic [1:0]  mask_reg;
	logic [1:0]  mask_next;
	logic [31:0] rdata_next;
	logic        err_next;
	logic        ready_next;
	logic        out_next_irq;

	logic                   cmp1_sync;
	logic                   cmp2_sync;
	dcc_pkg::dcc_cmp_cfg_t  cfg1;
	dcc_pkg::dcc_cmp_cfg_t  cfg2;
	dcc_pkg::dcc_cmp_stat_t st1;
	dcc_pkg::dcc_cmp_stat_t st2;

	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic wr_lo;
	logic wr_hi;
	logic [1:0] change;
	logic       irq_hold;

	// ----------------------------------------------------------------
	// Comparator channels
	// ----------------------------------------------------------------
	dcc_sync2 u_sync1 (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d_in    (cmp1_raw),
		.q_out   (cmp1_sync)
	);

	dcc_sync2 u_sync2 (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d_in    (cmp2_raw),
		.q_out   (cmp2_sync)
	);

	always_comb begin
		cfg1.enable    = ctrl_reg[dcc_pkg::CMP1_EN_BIT];
		cfg1.invert    = ctrl_reg[dcc_pkg::CMP1_INV_BIT];
		cfg1.minus_sel = ctrl_reg[dcc_pkg::CMP1_MINUS_BIT];
		cfg1.plus_sel  = ctrl_reg[dcc_pkg::CMP1_PLUS_BIT];
		cfg2.enable    = ctrl_reg[dcc_pkg::CMP2_EN_BIT];
		cfg2.invert    = ctrl_reg[dcc_pkg::CMP2_INV_BIT];
		cfg2.minus_sel = ctrl_reg[dcc_pkg::CMP2_MINUS_BIT];
		cfg2.plus_sel  = ctrl_reg[dcc_pkg::CMP2_PLUS_BIT];
	end

	dcc_channel u_ch1 (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.cfg      (cfg1),
		.raw_sync (cmp1_sync),
		.stat     (st1)
	);

	dcc_channel u_ch2 (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.cfg      (cfg2),
		.raw_sync (cmp2_sync),
		.stat     (st2)
	);

	// ----------------------------------------------------------------
	// APB decode and register update
	// ----------------------------------------------------------------
	// Setup phase is answered in the following access cycle with pready high.
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;
	assign rd_acc = setup & ~pwrite;
	assign wr_lo  = pstrb[0];
	assign wr_hi  = pstrb[1];
	assign change = {st2.changed, st1.changed};

	always_comb begin
		ctrl_next = ctrl_reg;
		stat_next = stat_reg;
		mask_next = mask_reg;
		if (wr_acc && paddr == dcc_pkg::CTRL_OFFSET) begin
			if (wr_lo) begin
				ctrl_next[7:0] = (pwdata[7:0] & dcc_pkg::CTRL_WRITE_MASK[7:0]) |
				                 (ctrl_reg[7:0] & ~dcc_pkg::CTRL_WRITE_MASK[7:0]);
			end
			if (wr_hi) begin
				ctrl_next[15:8] = (pwdata[15:8] & dcc_pkg::CTRL_WRITE_MASK[15:8]) |
				                  (ctrl_reg[15:8] & ~dcc_pkg::CTRL_WRITE_MASK[15:8]);
				// Event flags are cleared by writing a one, like the status register.
				ctrl_next[dcc_pkg::CMP2_EVENT_BIT] = ctrl_reg[dcc_pkg::CMP2_EVENT_BIT] &
				                                     ~pwdata[dcc_pkg::CMP2_EVENT_BIT];
				ctrl_next[dcc_pkg::CMP1_EVENT_BIT] = ctrl_reg[dcc_pkg::CMP1_EVENT_BIT] &
				                                     ~pwdata[dcc_pkg::CMP1_EVENT_BIT];
			end
		end
		if (wr_acc && wr_lo && paddr == dcc_pkg::IRQ_STAT_OFFSET) begin
			stat_next = stat_reg & ~pwdata[1:0];
		end
		if (wr_acc && wr_lo && paddr == dcc_pkg::IRQ_MASK_OFFSET) begin
			mask_next = pwdata[1:0];
		end
		// Hardware set wins over a clear in the same cycle.
		ctrl_next[dcc_pkg::CMP2_EVENT_BIT] = ctrl_next[dcc_pkg::CMP2_EVENT_BIT] | change[1];
		ctrl_next[dcc_pkg::CMP1_EVENT_BIT] = ctrl_next[dcc_pkg::CMP1_EVENT_BIT] | change[0];
		ctrl_next[dcc_pkg::CMP2_RESULT_BIT] = st2.result;
		ctrl_next[dcc_pkg::CMP1_RESULT_BIT] = st1.result;
		stat_next = stat_next | change;
	end

	// ----------------------------------------------------------------
	// Read path and outputs
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = 32'h0000_0000;
		err_next   = 1'b0;
		ready_next = setup;
		if (setup) begin
			case (paddr)
				dcc_pkg::CTRL_OFFSET:     rdata_next = {16'h0000, ctrl_reg};
				dcc_pkg::IRQ_STAT_OFFSET: rdata_next = {30'h0, stat_reg};
				dcc_pkg::IRQ_MASK_OFFSET: rdata_next = {30'h0, mask_reg};
				dcc_pkg::IDLE_OFFSET:     rdata_next = {31'h0, idle_mode};
				default:                  err_next   = 1'b1;
			endcase
			if (!rd_acc) begin
				rdata_next = 32'h0000_0000;
			end
		end
		// Idle with stop-in-idle holds the interrupt low; flags keep collecting.
		irq_hold     = idle_mode & ctrl_reg[dcc_pkg::STOP_IN_IDLE_BIT];
		out_next_irq = |(stat_reg & mask_reg) & ~irq_hold;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= dcc_pkg::CTRL_RESET;
			stat_reg     <= dcc_pkg::IRQ_RESET;
			mask_reg     <= dcc_pkg::IRQ_RESET;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			irq          <= 1'b0;
			cmp1_core_en <= 1'b0;
			cmp2_core_en <= 1'b0;
			cmp1_sel     <= 2'h0;
			cmp2_sel     <= 2'h0;
			cmp1_pin_out <= 1'b0;
			cmp1_pin_oe  <= 1'b0;
			cmp2_pin_out <= 1'b0;
			cmp2_pin_oe  <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			stat_reg     <= stat_next;
			mask_reg     <= mask_next;
			prdata       <= rdata_next;
			pready       <= ready_next;
			pslverr      <= err_next;
			irq          <= out_next_irq;
			cmp1_core_en <= ctrl_next[dcc_pkg::CMP1_EN_BIT];
			cmp2_core_en <= ctrl_next[dcc_pkg::CMP2_EN_BIT];
			cmp1_sel     <= ctrl_next[dcc_pkg::CMP1_MINUS_BIT:dcc_pkg::CMP1_PLUS_BIT];
			cmp2_sel     <= ctrl_next[dcc_pkg::CMP2_MINUS_BIT:dcc_pkg::CMP2_PLUS_BIT];
			cmp1_pin_out <= ctrl_next[dcc_pkg::CMP1_RESULT_BIT];
			cmp1_pin_oe  <= ctrl_next[dcc_pkg::CMP1_DRIVE_BIT];
			cmp2_pin_out <= ctrl_next[dcc_pkg::CMP2_RESULT_BIT];
			cmp2_pin_oe  <= ctrl_next[dcc_pkg::CMP2_DRIVE_BIT];
		end
	end
endmodule

// ===== dcc_properties.sv
// Purpose: Port-level properties of the comparator control block.
// Assumes: One clock domain; byte strobes gate which fields a write may change.
// Notes:   Derived outputs are checked one edge after a control write.
`timescale 1ns/10ps
module dcc_properties (
	input wire logic        sys_clk,      // Clock.
	input wire logic        rst_n,        // Reset, active low.
	input wire logic        psel,         // Select.
	input wire logic        penable,      // Enable.
	input wire logic        pwrite,       // Direction.
	input wire logic [7:0]  paddr,        // Address.
	input wire logic [31:0] pwdata,       // Write data.
	input wire logic [3:0]  pstrb,        // Byte strobes.
	input wire logic        pready,       // Ready.
	input wire logic        pslverr,      // Error.
	input wire logic        cmp1_core_en, // Enable 1.
	input wire logic        cmp2_core_en, // Enable 2.
	input wire logic [1:0]  cmp1_sel,     // Selects 1.
	input wire logic [1:0]  cmp2_sel,     // Selects 2.
	input wire logic        cmp1_pin_oe,  // Drive 1.
	input wire logic        cmp2_pin_oe   // Drive 2.
);
	logic ctrl_wr;
	assign ctrl_wr = psel && penable && pready && pwrite && paddr == dcc_pkg::CTRL_OFFSET;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	AST_READY_AFTER_SETUP: assert property (setup_s |=> answer_s)
		else $error("ready did not follow setup for one cycle");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_MAPPED_NO_ERR: assert property (pready && paddr[1:0] == 2'h0 && paddr < 8'h10
		|-> !pslverr)
		else $error("error on mapped address");
	AST_ENABLE: assert property (ctrl_wr && pstrb[1] |=>
		{cmp2_core_en, cmp1_core_en} == $past(pwdata[11:10]))
		else $error("enables do not follow write");
	AST_DRIVE: assert property (ctrl_wr && pstrb[1] |=>
		{cmp2_pin_oe, cmp1_pin_oe} == $past(pwdata[9:8]))
		else $error("pin drive does not follow write");
	AST_SELECT: assert property (ctrl_wr && pstrb[0] |=>
		{cmp2_sel, cmp1_sel} == $past(pwdata[3:0]))
		else $error("selects do not follow write");
	AST_CFG_HOLD: assert property ($changed({cmp2_core_en, cmp1_core_en, cmp2_pin_oe,
		cmp1_pin_oe, cmp2_sel, cmp1_sel}) |-> $past(ctrl_wr))
		else $error("config changed without write");
endmodule

// ===== dcc_core_model.sv
// Purpose: Behavioural model of one analog comparator core.
// Assumes: Small integers stand for input voltages.
// Notes:   The core tracks its inputs even when off; the block masks it.
`timescale 1ns/10ps
module dcc_core_model (
	input  wire logic [1:0] lvl_plus,  // Plus level.
	input  wire logic [1:0] lvl_minus, // Minus level.
	output logic            raw        // Plus above minus.
);
	assign raw = lvl_plus > lvl_minus;
endmodule

// ===== dual_comparator_control_tb.sv
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Byte strobes are random on control writes and all ones elsewhere.
// Notes:   Random writes reach every field; a model predicts each read.
`timescale 1ns/10ps
`define CHK(a, b) begin \
	compares++; \
	if ((a) !== (b)) begin \
		err_total++; \
		$display("BAD %0t got %h want %h", $time, a, b); \
	end \
end
bind dcc_top dcc_properties u_props (.sys_clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pready, .pslverr, .cmp1_core_en, .cmp2_core_en, .cmp1_sel,
	.cmp2_sel, .cmp1_pin_oe, .cmp2_pin_oe);
module dual_comparator_control_tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        idle_mode = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic [3:0]  strb = 4'hf;
	logic [31:0] prdata, q, w;
	logic        pready, pslverr, irq, e;
	logic [1:0]  cmp1_sel, cmp2_sel;
	wire  [1:0]  raw, core_en, pin_out, pin_oe;
	logic [1:0]  vp [2] = '{default: 2'h0};
	logic [1:0]  vm [2] = '{default: 2'h0};
	logic [15:0] m_ctrl = 16'h0;
	logic [1:0]  ev = 2'h0, res = 2'h0, st = 2'h0, mk = 2'h0;
	int          err_total = 0;
	int          compares = 0;
	dcc_core_model u_core1 (.lvl_plus(vp[0]), .lvl_minus(vm[0]), .raw(raw[0]));
	dcc_core_model u_core2 (.lvl_plus(vp[1]), .lvl_minus(vm[1]), .raw(raw[1]));
	dcc_top u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .cmp1_raw(raw[0]), .cmp2_raw(raw[1]),
		.idle_mode, .cmp1_core_en(core_en[0]), .cmp2_core_en(core_en[1]), .cmp1_sel,
		.cmp2_sel, .cmp1_pin_out(pin_out[0]), .cmp1_pin_oe(pin_oe[0]),
		.cmp2_pin_out(pin_out[1]), .cmp2_pin_oe(pin_oe[1]), .irq);
	always #5 sys_clk = ~sys_clk;
	// An idle edge first keeps two back-to-back calls from driving psel twice at once.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= strb;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1);
		`CHK(n, 1)
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic upd();
		logic [1:0] r;
		@(posedge sys_clk);
		for (int k = 0; k < 2; k++)
			r[k] = m_ctrl[10 + k] & ((vp[k] > vm[k]) ^ m_ctrl[4 + k]);
		ev |= r ^ res;
		st |= r ^ res;
		res = r;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic chk_all();
		apb(1'b0, dcc_pkg::CTRL_OFFSET, 32'h0);
		`CHK(q[15:0], m_ctrl | {2'b0, ev, 4'h0, res, 6'h0})
		apb(1'b0, dcc_pkg::IRQ_STAT_OFFSET, 32'h0);
		`CHK(q, {30'h0, st})
		apb(1'b0, dcc_pkg::IRQ_MASK_OFFSET, 32'h0);
		`CHK(q, {30'h0, mk})
		apb(1'b0, dcc_pkg::IDLE_OFFSET, 32'h0);
		`CHK(q, {31'h0, idle_mode})
		`CHK({core_en, pin_oe}, m_ctrl[11:8])
		`CHK({pin_out, cmp2_sel, cmp1_sel}, {res, m_ctrl[3:0]})
		`CHK(irq, |(st & mk) & ~(idle_mode & m_ctrl[15]))
	endtask
	task automatic stop_test();
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(71506));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		apb(1'b1, 8'h40, 32'hffff);
		`CHK(e, 1'b1)
		chk_all();
		apb(1'b0, 8'h10, 32'h0);
		`CHK({e, q}, {1'b1, 32'h0})
		for (int i = 0; i < 32; i++) begin
			w = $urandom;
			// Lanes 3 and 2 are random too; the block must ignore them.
			strb = w[19:16];
			apb(1'b1, dcc_pkg::CTRL_OFFSET, w);
			strb = 4'hf;
			if (w[16])
				m_ctrl[7:0] = w[7:0] & dcc_pkg::CTRL_WRITE_MASK[7:0];
			if (w[17]) begin
				m_ctrl[15:8] = w[15:8] & dcc_pkg::CTRL_WRITE_MASK[15:8];
				ev &= ~w[13:12];
			end
			upd();
			w = $urandom;
			{vp[0], vm[0], vp[1], vm[1]} <= w[7:0];
			upd();
			apb(1'b1, dcc_pkg::IRQ_STAT_OFFSET, w >> 8);
			st &= ~w[9:8];
			apb(1'b1, dcc_pkg::IRQ_MASK_OFFSET, w >> 10);
			mk = w[11:10];
			idle_mode <= w[12];
			chk_all();
		end
		stop_test();
	end
	// The whole sequence needs under 3000 cycles; the margin covers a slow answer.
	initial begin
		#100us;
		err_total++;
		stop_test();
	end
endmodule
